// ==== pmi_pkg.sv ====
// Constants, types and helpers for the PHY-side MAC data interface
package pmi_pkg;

   // ==========================================================
   // Clock rates, in kHz as printed
   localparam int CLK_KHZ     = 125000;  // System clock, 8 ns
   localparam int F_MII100_KHZ = 25000;  // MII clocks at 100 Mb/s
   localparam int F_MII10_KHZ = 2500;    // MII clocks at 10 Mb/s
   localparam int F_SNI_KHZ   = 10000;   // Serial mode clocks
   localparam int F_RMII_KHZ  = 50000;   // RMII reference rate

   // ==========================================================
   // Phase accumulator: one tick per half period of a clock
   localparam int NCO_W = 18;
   localparam logic [NCO_W-1:0] NCO_MOD    = NCO_W'(CLK_KHZ);
   localparam logic [NCO_W-1:0] INC_MII100 = NCO_W'(2 * F_MII100_KHZ);
   localparam logic [NCO_W-1:0] INC_MII10  = NCO_W'(2 * F_MII10_KHZ);
   localparam logic [NCO_W-1:0] INC_SNI    = NCO_W'(2 * F_SNI_KHZ);
   localparam logic [NCO_W-1:0] INC_RMII   = NCO_W'(2 * F_RMII_KHZ);
   localparam logic [NCO_W-1:0] NCO_ZERO   = 18'h00000;

   // ==========================================================
   // Data path
   localparam int DATA_W     = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [1:0] RMII_ERR_DIBIT = 2'h2;  // Forced on bad receive
   localparam logic [3:0] NIBBLE_ZERO    = 4'h0;

   // Interface modes
   typedef enum logic [2:0] {
      PMI_MII  = 3'b001,
      PMI_RMII = 3'b010,
      PMI_SNI  = 3'b100
   } pmi_mode_t;

   // Step a phase accumulator; returns {tick, new phase}
   function automatic logic [NCO_W:0] pmi_nco(
      input logic [NCO_W-1:0] acc,
      input logic [NCO_W-1:0] inc
   );
      logic [NCO_W:0] sum;
      sum = {1'b0, acc} + {1'b0, inc};
      if (sum >= {1'b0, NCO_MOD}) begin
         pmi_nco = {1'b1, NCO_W'(sum - {1'b0, NCO_MOD})};
      end else begin
         pmi_nco = {1'b0, sum[NCO_W-1:0]};
      end
   endfunction

endpackage

// ==== pmi_fifo.sv ====
// Synchronous FIFO with a registered output stage
`timescale 1ns/1ps

module pmi_fifo #(
   parameter int W     = 4,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // State
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [AW:0]             count;
      logic [W-1:0]            data;
      logic                    valid;
   } pmi_fifo_st_t;

   pmi_fifo_st_t s;
   pmi_fifo_st_t next_s;

   // Full is exact: output stage not counted, so DEPTH+1 words fit
   assign in_ready  = (s.count != (AW+1)'(DEPTH));
   assign out_valid = s.valid;
   assign out_data  = s.data;

   // Write, and refill the output register when it drains
   always_comb begin
      logic push;
      logic pop;
      push   = 1'b0;
      pop    = 1'b0;
      next_s = s;
      push   = in_valid && in_ready;
      pop    = (!s.valid || out_ready) && (s.count != '0);
      if (out_ready) begin
         next_s.valid = 1'b0;
      end
      if (pop) begin
         next_s.data  = s.mem[s.rd];
         next_s.valid = 1'b1;
         next_s.rd    = s.rd + 1'b1;
      end
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr        = s.wr + 1'b1;
      end
      next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

// ==== pmi_port.sv ====
// One port of the PHY-side MAC data interface (MII, RMII, serial)
`timescale 1ns/1ps

module pmi_port
   import pmi_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Configuration
   input  wire pmi_mode_t       cfg_mode,
   input  wire logic            cfg_speed_100,
   // MAC transmit side
   output logic                 tx_clk,
   input  wire logic            tx_en,
   input  wire logic [3:0]      txd,
   // MAC receive side
   output logic                 rx_clk,
   output logic      [3:0]      rxd,
   output logic                 rx_dv,
   output logic                 rx_er,
   output logic                 crs_dv,
   // Line-facing transmit stream
   output logic      [DATA_W-1:0] line_tx_data,
   output logic                 line_tx_valid,
   input  wire logic            line_tx_ready,
   output logic                 tx_active,
   output logic                 tx_overrun,
   // Line-facing receive side
   input  wire logic            line_rx_tick,
   input  wire logic [3:0]      line_rx_data,
   input  wire logic            line_rx_valid,
   input  wire logic            line_rx_sym_err,
   input  wire logic            line_carrier,
   input  wire logic            line_false_carrier,
   // Active mode, as latched
   output pmi_mode_t            mode,
   output logic                 speed_100
);

   // ==========================================================
   // State
   typedef struct packed {
      pmi_mode_t        mode;
      logic             speed_100;
      logic [NCO_W-1:0] tx_acc;
      logic [NCO_W-1:0] ref_acc;
      logic             tx_clk;
      logic             ref_ph;
      logic             rx_clk;
      logic             tx_active;
      logic             tx_overrun;
      logic [3:0]       rxd;
      logic             rx_dv;
      logic             rx_er;
      logic             crs;
   } pmi_st_t;

   pmi_st_t s;
   pmi_st_t next_s;

   logic              fifo_in_ready;
   logic              push;
   logic [DATA_W-1:0] tx_word;

   // ==========================================================
   // Helpers
   // Half-period tick seen while the clock is high: a falling edge
   function automatic logic pmi_fall(
      input logic tick,
      input logic level
   );
      pmi_fall = tick && level;
   endfunction

   // Divided clock; parked low so a MAC never sees a stray edge
   function automatic logic pmi_next_clk(
      input logic cur,
      input logic tick,
      input logic park
   );
      if (park) begin
         pmi_next_clk = 1'b0;
      end else if (tick) begin
         pmi_next_clk = !cur;
      end else begin
         pmi_next_clk = cur;
      end
   endfunction

   // Transmit lanes per mode; unused lanes zero so words compare cleanly
   function automatic logic [DATA_W-1:0] pmi_tx_lanes(
      input pmi_mode_t  m,
      input logic [3:0] d
   );
      unique case (m)
         PMI_RMII: pmi_tx_lanes = {2'h0, d[1:0]};
         PMI_SNI:  pmi_tx_lanes = {3'h0, d[0]};
         default:  pmi_tx_lanes = d;
      endcase
   endfunction

   // Merged carrier/valid: toggles out the tail while data drains
   function automatic logic pmi_crs_dv(
      input logic cur,
      input logic carrier,
      input logic valid
   );
      if (carrier) begin
         pmi_crs_dv = 1'b1;
      end else if (valid) begin
         pmi_crs_dv = !cur;
      end else begin
         pmi_crs_dv = 1'b0;
      end
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [NCO_W:0]   tx_nco;
      logic [NCO_W:0]   ref_nco;
      logic [NCO_W-1:0] tx_inc;
      logic             is_rmii;
      logic             tx_fall;
      logic             ref_fall;
      logic             rx_fall;
      logic             samp;
      logic             rx_upd;
      logic             idle;
      logic             bad;
      tx_nco   = '0;
      ref_nco  = '0;
      tx_inc   = NCO_ZERO;
      is_rmii  = 1'b0;
      tx_fall  = 1'b0;
      ref_fall = 1'b0;
      rx_fall  = 1'b0;
      samp     = 1'b0;
      rx_upd   = 1'b0;
      idle     = 1'b0;
      bad      = 1'b0;
      next_s   = s;
      push     = 1'b0;
      tx_word  = NIBBLE_ZERO;

      // mode latch: a mid-frame change would split a frame
      idle = !tx_en && !s.tx_active && !line_carrier && !line_rx_valid
             && !s.crs && !s.rx_dv;
      if (idle) begin
         next_s.speed_100 = cfg_speed_100;
         unique case (cfg_mode)
            PMI_MII, PMI_RMII, PMI_SNI: next_s.mode = cfg_mode;
            default:                    next_s.mode = PMI_MII;
         endcase
      end
      // RMII parks both clocks and runs from the reference
      is_rmii = (s.mode == PMI_RMII);

      // transmit clock rate from the shared reference
      if (s.mode == PMI_SNI) begin
         tx_inc = INC_SNI;
      end else if (s.speed_100) begin
         tx_inc = INC_MII100;
      end else begin
         tx_inc = INC_MII10;
      end
      tx_nco        = pmi_nco(s.tx_acc, tx_inc);
      next_s.tx_acc = tx_nco[NCO_W-1:0];
      tx_fall       = pmi_fall(tx_nco[NCO_W], s.tx_clk);
      next_s.tx_clk = pmi_next_clk(s.tx_clk, tx_nco[NCO_W], is_rmii);

      ref_nco        = pmi_nco(s.ref_acc, INC_RMII);
      next_s.ref_acc = ref_nco[NCO_W-1:0];
      ref_fall       = pmi_fall(ref_nco[NCO_W], s.ref_ph);
      if (ref_nco[NCO_W]) begin
         next_s.ref_ph = !s.ref_ph;
      end

      // sample mid-cycle, away from the MAC's launch edge
      samp = is_rmii ? ref_fall : tx_fall;
      tx_word = pmi_tx_lanes(s.mode, txd);
      push = samp && tx_en;
      if (samp) begin
         next_s.tx_active = tx_en;
      end
      // Overrun is sticky per frame; the first idle sample clears it, set wins
      if (samp && !tx_en) begin
         next_s.tx_overrun = 1'b0;
      end
      if (push && !fifo_in_ready) begin
         next_s.tx_overrun = 1'b1;
      end

      // receive clock follows recovered line ticks
      rx_fall       = pmi_fall(line_rx_tick, s.rx_clk);
      next_s.rx_clk = pmi_next_clk(s.rx_clk, line_rx_tick, is_rmii);

      // RMII receive timed from the reference
      rx_upd = is_rmii ? ref_fall : rx_fall;
      if (rx_upd) begin
         unique case (s.mode)
            PMI_RMII: begin
               // merged carrier/valid toggles out the tail
               next_s.crs = pmi_crs_dv(s.crs, line_carrier, line_rx_valid);
               next_s.rx_dv = line_rx_valid;
               // error on bad symbol or false carrier
               bad = (s.speed_100 && line_rx_sym_err && next_s.crs)
                     || line_false_carrier;
               next_s.rx_er = bad;
               // corrupt data so a MAC ignoring the error sees it
               next_s.rxd = bad ? {2'b00, RMII_ERR_DIBIT}
                                : {2'b00, line_rx_data[1:0]};
            end
            PMI_SNI: begin
               // one bit framed by carrier sense
               next_s.crs   = line_carrier;
               next_s.rxd   = {3'b000, line_rx_data[0]};
               next_s.rx_dv = 1'b0;
               next_s.rx_er = 1'b0;
            end
            default: begin
               next_s.crs   = line_carrier;
               next_s.rx_dv = line_rx_valid;
               next_s.rxd   = line_rx_valid ? line_rx_data : NIBBLE_ZERO;
               // symbol error at 100 Mb/s within packet
               next_s.rx_er = s.speed_100 && line_rx_valid
                              && line_rx_sym_err;
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s      <= '0;
         s.mode <= PMI_MII;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Transmit buffer toward the line; full drops and flags overrun
   pmi_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (tx_word),
      .out_valid (line_tx_valid),
      .out_ready (line_tx_ready),
      .out_data  (line_tx_data)
   );

   // Outputs straight from state
   assign tx_clk     = s.tx_clk;
   assign rx_clk     = s.rx_clk;
   assign rxd        = s.rxd;
   assign rx_dv      = s.rx_dv;
   assign rx_er      = s.rx_er;
   assign crs_dv     = s.crs;
   assign tx_active  = s.tx_active;
   assign tx_overrun = s.tx_overrun;
   assign mode       = s.mode;
   assign speed_100  = s.speed_100;

endmodule

// ==== pmi_port_sva.sv ====
// Timing checks on the MAC data interface port
`timescale 1ns/1ps

module pmi_port_sva
   import pmi_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              tx_clk,
   input wire logic              rx_clk,
   input wire logic [3:0]        rxd,
   input wire logic              rx_dv,
   input wire logic              rx_er,
   input wire logic              crs_dv,
   input wire logic [DATA_W-1:0] line_tx_data,
   input wire logic              line_tx_valid,
   input wire logic              line_tx_ready,
   input wire logic              line_rx_tick,
   input wire logic [3:0]        line_rx_data,
   input wire logic              line_rx_valid,
   input wire logic              line_rx_sym_err,
   input wire logic              line_carrier,
   input wire logic              line_false_carrier,
   input wire pmi_mode_t         mode,
   input wire logic              speed_100
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ====
   // Receive update point in MII
   logic mii;
   logic upd;
   assign mii = (mode == PMI_MII);
   assign upd = line_rx_tick && rx_clk && mii;

   a_rmii_clk_idle: assert property (
      (mode == PMI_RMII) [*3] |-> !tx_clk && !rx_clk)
      else $error("clock running in RMII");
   // Guard on mode: an idle reload may stop the clock mid-period
   a_mii100_rate: assert property (
      $changed(tx_clk) && mii && speed_100 |-> ##1 ($stable(tx_clk) || !mii)
      ##[1:2] ($changed(tx_clk) || !mii)) else $error("bad 25 MHz edge");
   // First edge after a mode load may come early: phase left from MII
   a_sni_rate: assert property (
      $changed(tx_clk) && mode == PMI_SNI && $past(mode) == PMI_SNI
      |-> ##1 $stable(tx_clk) [*5] ##[1:2] $changed(tx_clk))
      else $error("bad 10 MHz edge");
   a_rx_clk_tick: assert property (
      (mode != PMI_RMII) [*2] |-> $changed(rx_clk) == $past(line_rx_tick))
      else $error("receive clock off tick");
   a_mii_rx_update: assert property (
      upd |=> rx_dv == $past(line_rx_valid) && crs_dv == $past(line_carrier)
      && rxd == ($past(line_rx_valid) ? $past(line_rx_data) : 4'h0))
      else $error("MII receive word wrong");
   a_mii_rx_err: assert property (
      upd |=> rx_er == ($past(speed_100) && $past(line_rx_valid)
      && $past(line_rx_sym_err))) else $error("MII receive error wrong");
   a_rmii_err_data: assert property (
      mode == PMI_RMII && rx_er |-> rxd[1:0] == RMII_ERR_DIBIT)
      else $error("bad dibit not corrupted");
   a_rmii_false_car: assert property (
      (mode == PMI_RMII && line_false_carrier) [*4] |-> rx_er)
      else $error("false carrier not flagged");
   a_tx_hold_word: assert property (
      line_tx_valid && !line_tx_ready |=> line_tx_valid
      && $stable(line_tx_data)) else $error("stream word dropped");

   c_tx_word: cover property (line_tx_valid && line_tx_ready);
   c_rmii_err: cover property (mode == PMI_RMII && rx_er);
   c_mii_rx: cover property (upd && line_rx_valid);
endmodule

// ==== pmi_mac_model.sv ====
// MAC transmit model: one word per rising transmit clock
`timescale 1ns/1ps

module pmi_mac_model (
   input  wire logic       clk,
   input  wire logic       tx_clk,
   input  wire logic [4:0] count,
   output logic            tx_en,
   output logic      [3:0] txd
);
   logic       clk_q;
   logic [4:0] sent;

   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
      clk_q = 1'b0;
      sent = 5'h00;
   end

   // ====
   // launch on rising transmit clock
   always @(posedge clk) begin
      clk_q <= tx_clk;
      if (count == 5'h00) begin
         sent <= 5'h00;
         tx_en <= 1'b0;
      end else if (tx_clk && !clk_q) begin
         // enable high only with valid words
         if (sent < count) begin
            tx_en <= 1'b1;
            txd <= 4'(sent + 5'h01);
            sent <= sent + 5'h01;
         end else begin
            tx_en <= 1'b0;
            txd <= ~txd;  // Released line shows no stale word
         end
      end
   end
endmodule

// ==== tb_pmi_port.sv ====
// Self-checking bench for one MAC data interface port
`timescale 1ns/1ps

module tb_pmi_port;
   import pmi_pkg::*;
   logic       clk, rst_n, cfg_speed_100, tx_clk, tx_en, rx_clk, rx_dv;
   logic       rx_er, crs_dv, line_tx_valid, line_tx_ready, tx_active;
   logic       tx_overrun, line_rx_tick, line_rx_valid, line_rx_sym_err;
   logic       line_carrier, line_false_carrier, speed_100, tick_en;
   logic [3:0] txd, rxd, line_tx_data, line_rx_data;
   logic [4:0] mac_count;
   pmi_mode_t  cfg_mode, mode;
   int         mismatches, comparisons;

   pmi_port u_dut (
      .clk(clk), .rst_n(rst_n), .cfg_mode(cfg_mode),
      .cfg_speed_100(cfg_speed_100), .tx_clk(tx_clk), .tx_en(tx_en),
      .txd(txd), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
      .crs_dv(crs_dv), .line_tx_data(line_tx_data),
      .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
      .tx_active(tx_active), .tx_overrun(tx_overrun),
      .line_rx_tick(line_rx_tick), .line_rx_data(line_rx_data),
      .line_rx_valid(line_rx_valid), .line_rx_sym_err(line_rx_sym_err),
      .line_carrier(line_carrier), .line_false_carrier(line_false_carrier),
      .mode(mode), .speed_100(speed_100));
   pmi_mac_model u_mac (
      .clk(clk), .tx_clk(tx_clk), .count(mac_count), .tx_en(tx_en),
      .txd(txd));

   // ====
   // Clock, and a line tick every second cycle
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) line_rx_tick <= tick_en && !line_rx_tick;

   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Reset with a new configuration, line side idle
   task automatic restart(input pmi_mode_t m, input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      cfg_mode <= m;
      cfg_speed_100 <= s;
      mac_count <= 5'h00;
      line_tx_ready <= 1'b0;
      tick_en <= 1'b1;
      {line_carrier, line_rx_valid, line_rx_sym_err} <= 3'h0;
      line_false_carrier <= 1'b0;
      line_rx_data <= 4'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   // Take n words from the stream; word k carries k under the mode mask
   task automatic drain(input int n, input logic [3:0] msk);
      int got;
      int k;
      got = 0;
      @(posedge clk);
      line_tx_ready <= 1'b1;
      for (k = 0; k < 2000 && got < n; k++) begin
         @(negedge clk);
         if (line_tx_valid && line_tx_ready) begin
            got++;
            check(line_tx_data, 4'(got) & msk);
         end
      end
      check(4'(got), 4'(n));
      if (got != n) stop_test();
   endtask

   task automatic t_tx(input pmi_mode_t m, input logic s,
                       input logic [3:0] msk, input int n);
      restart(m, s);
      mac_count <= 5'(n);
      drain(n, msk);
   endtask

   // Stalled stream: nine words kept, the tenth dropped and flagged
   task automatic t_overrun();
      int k;
      restart(PMI_MII, 1'b1);
      mac_count <= 5'h0C;
      for (k = 0; k < 300 && tx_overrun !== 1'b1; k++) @(negedge clk);
      check(tx_overrun, 1'b1);
      check(tx_active, 1'b1);
      if (tx_overrun !== 1'b1) stop_test();
      drain(9, 4'hF);
      for (k = 0; k < 300 && tx_overrun !== 1'b0; k++) @(negedge clk);
      check(tx_overrun, 1'b0);
      check(tx_active, 1'b0);
      if (tx_overrun !== 1'b0) stop_test();
   endtask

   task automatic t_mii_rx(input logic s);
      restart(PMI_MII, s);
      {line_carrier, line_rx_valid, line_rx_sym_err} <= 3'h7;
      line_rx_data <= 4'hA;
      repeat (8) @(negedge clk);
      check(rxd, 4'hA);
      check({rx_dv, crs_dv}, 2'h3);
      check(rx_er, s);
      @(posedge clk);
      {line_carrier, line_rx_valid, line_rx_sym_err} <= 3'h0;
      repeat (8) @(negedge clk);
      check(rxd, 4'h0);
      check(rx_dv, 1'b0);
   endtask

   task automatic t_sni_rx();
      restart(PMI_SNI, 1'b0);
      line_carrier <= 1'b1;
      line_rx_data <= 4'h1;
      repeat (8) @(negedge clk);
      check({rxd[0], crs_dv}, 2'h3);
   endtask

   task automatic t_rmii_rx();
      restart(PMI_RMII, 1'b1);
      {line_carrier, line_rx_valid, line_rx_sym_err} <= 3'h7;
      line_rx_data <= 4'h1;
      repeat (8) @(negedge clk);
      check({rx_er, crs_dv}, 2'h3);
      check(rxd[1:0], RMII_ERR_DIBIT);
      check({tx_clk, rx_clk}, 2'h0);
      @(posedge clk);
      line_rx_sym_err <= 1'b0;
      repeat (8) @(negedge clk);
      check({rxd[1:0], rx_dv}, 3'h3);
      @(posedge clk);
      {line_carrier, line_rx_valid, line_false_carrier} <= 3'h1;
      repeat (8) @(negedge clk);
      check(rx_er, 1'b1);
   endtask

   // New mode waits while the medium is busy
   task automatic t_cfg_hold();
      restart(PMI_MII, 1'b1);
      line_carrier <= 1'b1;
      repeat (8) @(posedge clk);
      cfg_mode <= PMI_SNI;
      cfg_speed_100 <= 1'b0;
      repeat (8) @(negedge clk);
      check(4'(mode), 4'(PMI_MII));
      check(speed_100, 1'b1);
      @(posedge clk);
      line_carrier <= 1'b0;
      repeat (12) @(negedge clk);
      check(4'(mode), 4'(PMI_SNI));
      check(speed_100, 1'b0);
   endtask

   initial begin
      mismatches = 0;
      comparisons = 0;
      {rst_n, cfg_speed_100, line_tx_ready, tick_en} = 4'h0;
      {line_rx_tick, line_carrier, line_rx_valid} = 3'h0;
      {line_rx_sym_err, line_false_carrier} = 2'h0;
      cfg_mode = PMI_MII;
      mac_count = 5'h00;
      line_rx_data = 4'h0;
      t_tx(PMI_MII, 1'b1, 4'hF, 6);
      t_tx(PMI_MII, 1'b0, 4'hF, 3);
      t_tx(PMI_SNI, 1'b0, 4'h1, 4);
      t_overrun();
      t_mii_rx(1'b1);
      t_mii_rx(1'b0);
      t_sni_rx();
      t_rmii_rx();
      t_cfg_hold();
      stop_test();
   end
endmodule

bind pmi_port pmi_port_sva u_sva (
   .clk(clk), .rst_n(rst_n), .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd),
   .rx_dv(rx_dv), .rx_er(rx_er), .crs_dv(crs_dv),
   .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
   .line_tx_ready(line_tx_ready), .line_rx_tick(line_rx_tick),
   .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
   .line_rx_sym_err(line_rx_sym_err), .line_carrier(line_carrier),
   .line_false_carrier(line_false_carrier), .mode(mode),
   .speed_100(speed_100));
